// File: src/dim_field_upd.v
// write-control field update for a group of control-over-value bit pairs
`timescale 1ns/10ps
module dim_field_upd #(
  parameter N = 3
) (
  // current values and host write word
  input wire [N-1:0] cur,
  input wire [2*N-1:0] wdata,
  // updated values
  output reg [N-1:0] upd
);
  integer i;
  always @* begin
    upd = cur;
    for (i = 0; i < N; i = i + 1) begin
      if (wdata[2*i+1]) begin
        upd[i] = wdata[2*i];
      end
    end
  end
endmodule

// File: src/dim_irq.v
// interrupt flag and mask registers of the display controller
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`include "dim_regs.vh"
module dim_irq (
  // clock and reset
  input wire clk,
  input wire srst,
  // avalon-mm slave
  input wire [`DIM_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // condition events, one-cycle or level
  input wire vblank_event,
  input wire pick_event,
  input wire engine_idle_event,
  // interrupt toward the host, active low
  output reg host_irq_out_n
);
  // handshake states, one-hot
  localparam ST_IDLE = 2'b01;
  localparam ST_ACK = 2'b10;

  // flag order: bit0 idle, bit1 pick, bit2 vblank
  reg [2:0] flags;
  // mask order: bit0 idle, bit1 pick, bit2 vblank, bit3 master
  reg [3:0] mask;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] next_readdata;

  wire [2:0] flag_wr;
  wire [3:0] mask_wr;
  wire [2:0] events;
  wire idle_st;
  wire wr_go;
  wire rd_go;
  wire flag_sel;
  wire mask_sel;
  wire lane0;
  wire flag_load;
  wire mask_load;
  wire engine_idle_flag;
  wire engine_idle_irq_enable;
  wire pick_hit;
  wire vblank_hit;
  wire idle_hit;
  wire master_on;
  wire [2:0] next_flags;
  wire [3:0] next_mask;
  wire next_irq;
  wire next_waitrequest;

  // true when the byte address selects the given register word
  function addr_hit;
    input [`DIM_ADDR_W-1:0] addr;
    input [`DIM_ADDR_W-1:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // puts each value bit in its field; control bits read back as zero
  function [7:0] spread;
    input [3:0] val;
    begin
      spread = 8'h00;
      spread[`DIM_IDLE_BIT] = val[0];
      spread[`DIM_PICK_BIT] = val[1];
      spread[`DIM_VBL_BIT] = val[2];
      spread[`DIM_MASTER_BIT] = val[3];
    end
  endfunction

  assign events = {vblank_event, pick_event, engine_idle_event};

  // address and lane decode
  assign flag_sel = addr_hit(avs_address, `DIM_FLAG_OFS);
  assign mask_sel = addr_hit(avs_address, `DIM_MASK_OFS);
  // all fields live in the low byte, so only lane 0 can write them
  assign lane0 = avs_byteenable[0];

  // every access takes one wait cycle so readdata comes from a flop
  assign idle_st = (state == ST_IDLE);
  assign wr_go = avs_write & idle_st;
  assign rd_go = avs_read & idle_st;

  assign flag_load = wr_go & flag_sel & lane0;
  assign mask_load = wr_go & mask_sel & lane0;

  dim_field_upd #(.N(3)) u_flag_upd (
    .cur(flags),
    .wdata(avs_writedata[5:0]),
    .upd(flag_wr)
  );

  dim_field_upd #(.N(4)) u_mask_upd (
    .cur(mask),
    .wdata(avs_writedata[7:0]),
    .upd(mask_wr)
  );

  // host write of flags through the control bits
  // events are ored in last, so a set beats a clear
  assign next_flags = (flag_load ? flag_wr : flags) | events;

  assign next_mask = mask_load ? mask_wr : mask;

  // per-condition hits of the current flags and enables
  assign engine_idle_flag = flags[0];
  assign engine_idle_irq_enable = mask[0];
  assign idle_hit = engine_idle_flag & engine_idle_irq_enable;
  assign pick_hit = flags[1] & mask[1];
  assign vblank_hit = flags[2] & mask[2];
  assign master_on = mask[3];

  // enabled flag gated by master enable
  // a flag set by software counts the same as one set by an event
  assign next_irq = master_on & (idle_hit | pick_hit | vblank_hit);

  // bus handshake: one acknowledge cycle per access
  always @* begin
    next_state = ST_IDLE;
    case (state)
      ST_IDLE: begin
        if (avs_read || avs_write) begin
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // waitrequest drops only for the acknowledge cycle
  assign next_waitrequest = (next_state != ST_ACK);

  // control bits, upper bits and unmapped words read zero
  always @* begin
    next_readdata = avs_readdata;
    if (rd_go) begin
      if (flag_sel) begin
        next_readdata = {24'h0, spread({1'b0, flags})};
      end else if (mask_sel) begin
        next_readdata = {24'h0, spread(mask)};
      end else begin
        next_readdata = 32'h0;
      end
    end
  end

  // handshake state and waitrequest
  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      state <= next_state;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // sticky flags
  always @(posedge clk) begin
    if (srst) begin
      flags <= `DIM_FLAG_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // enables and master enable
  always @(posedge clk) begin
    if (srst) begin
      mask <= `DIM_MASK_RST;
    end else begin
      mask <= next_mask;
    end
  end

  // read data holds until the next read
  always @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h0;
    end else begin
      avs_readdata <= next_readdata;
    end
  end

  // irq is registered, so it follows a flag change by one cycle
  always @(posedge clk) begin
    if (srst) begin
      host_irq_out_n <= 1'b1;
    end else begin
      host_irq_out_n <= ~next_irq;
    end
  end

endmodule

// File: src/dim_regs.vh
// register offsets, field positions and reset values of the irq flag block
`ifndef DIM_REGS_VH
`define DIM_REGS_VH
`define DIM_ADDR_W 4
`define DIM_FLAG_OFS 4'h0
`define DIM_MASK_OFS 4'h4
`define DIM_IDLE_BIT 0
`define DIM_PICK_BIT 2
`define DIM_VBL_BIT 4
`define DIM_MASTER_BIT 6
`define DIM_FLAG_RST 3'h0
`define DIM_MASK_RST 4'h0
`endif

// File: testbench/dim_host.sv
// host side: registers the active-low irq line
`timescale 1ns/10ps
module dim_host(input wire clk,host_irq_out_n,output reg seen);
  always @(posedge clk) seen<=!host_irq_out_n;
endmodule

// File: testbench/dim_irq_sva.sv
// port assertions of the irq flag block
`timescale 1ns/10ps
module dim_irq_sva (
  // clock and reset
  input wire clk,
  input wire srst,
  // register bus
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // events and interrupt
  input wire vblank_event,
  input wire pick_event,
  input wire engine_idle_event,
  input wire host_irq_out_n
);
  wire w=avs_waitrequest,n=host_irq_out_n,r=avs_read,q=r|avs_write;
  wire d=vblank_event|pick_event|engine_idle_event;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ack_due_a: assert property (q&&w|=>!w) else $error("no ack");
  ack_one_a: assert property (!w|=>w) else $error("long ack");
  ack_why_a: assert property (!w|->$past(q)) else $error("stray");
  flag_rd_a: assert property (r&&!w&&avs_address==4'h0|->
    !(avs_readdata&~32'h15)) else $error("flag");
  hole_rd_a: assert property (r&&!w&&(|avs_address[1:0]||avs_address[3])
    |->avs_readdata==32'h0) else $error("hole");
  irq_set_a: assert property ($fell(n)|->$past(d|avs_write,2))
    else $error("irq set");
  irq_clr_a: assert property ($rose(n)|->$past(avs_write,2)||$past(srst))
    else $error("irq clr");
  nop_wr_a: assert property (avs_write&&w&&!(avs_writedata&32'haa)
    |->##2 !$rose(n)) else $error("nop");
  cover property ($fell(n));
  cover property ($rose(n));
  cover property (r&&!w);
endmodule
bind dim_irq dim_irq_sva u_dim_irq_sva(.*);

// File: testbench/tb_top.sv
// self-checking bench of the irq flag block
`timescale 1ns/10ps
module tb_top;
  reg clk=0,srst=1,avs_read=0,avs_write=0;
  reg [2:0] ev=3'h0;
  reg [3:0] avs_address=4'h0,avs_byteenable=4'hf;
  reg [31:0] avs_writedata=32'h0,q[$];
  wire [31:0] avs_readdata;
  wire avs_waitrequest,host_irq_out_n,seen,w=avs_waitrequest,n=host_irq_out_n;
  wire vblank_event=ev[2],pick_event=ev[1],engine_idle_event=ev[0];
  integer errors=0,samples_checked=0,i;
  dim_irq u_dim_irq(.*);
  dim_host u_dim_host(.*);
  initial forever #20 clk=~clk;
  task chk(input [8*12:1] nm,input [31:0] s,e); begin
    samples_checked++;
    if(s!==e) begin
      errors++;
      $display("Error %0s exp %h got %h",nm,e,s);
    end
  end endtask
  // request held until waitrequest is seen low
  task bus(input v,input [3:0] x,input [31:0] d); begin
    {avs_read,avs_write,avs_address,avs_writedata}<={!v,v,x,d};
    @(posedge clk);
    while(w) @(posedge clk);
    {avs_read,avs_write}<=2'h0;
    @(posedge clk);
  end endtask
  task rdc(input [3:0] x,input [31:0] e); begin
    q.push_back(e);
    bus(0,x,0);
  end endtask
  task pul(input [2:0] m,input e); begin
    ev<=m;
    @(posedge clk);
    ev<=3'h0;
    repeat(3) @(posedge clk);
    chk("irq",n,e);
    chk("host seen",seen,!e);
  end endtask
  always @(posedge clk)
    if(avs_read&&!w) chk("readdata",avs_readdata,q.pop_front());
  task end_sim; begin
    $display("checks %0d errors %0d",samples_checked,errors);
    if(errors==0&&samples_checked>0) $display("verification passed");
    else $display("verification failed");
    $finish;
  end endtask
  initial begin
    repeat(3000) @(posedge clk);
    errors++;
    end_sim;
  end
  initial begin
    i=$urandom(32'h13355de2);
    repeat(12) @(posedge clk);
    srst<=0;
    rdc(8,0);
    bus(1,4,8'hff);
    for(i=0;i<3;i++) begin
      pul(3'h4>>i,0);
      bus(1,0,$urandom&~32'hff|8'h15);
      rdc(0,8'h10>>2*i);
      bus(1,0,8'h20>>2*i);
      chk("irq",n,1);
    end
    bus(1,4,8'h80);
    pul(3'h2,1);
    bus(1,4,8'hc0);
    chk("irq",n,0);
    bus(1,0,8'h08);
    bus(1,0,8'h30);
    chk("irq",n,0);
    rdc(0,8'h10);
    avs_byteenable<=4'he;
    bus(1,0,8'h20);
    avs_byteenable<=4'hf;
    rdc(0,8'h10);
    end_sim;
  end
endmodule
